// file: core/dopc_pkg.sv
// constants, field layouts and carriers of the dual output modulator
package dopc_pkg;
    // register addresses on the special function bus
    localparam logic [7:0] ADDR_CTRL   = 8'hae;
    localparam logic [7:0] ADDR_A_LOW  = 8'hb1;
    localparam logic [7:0] ADDR_A_HIGH = 8'hb2;
    localparam logic [7:0] ADDR_B_LOW  = 8'hb3;
    localparam logic [7:0] ADDR_B_HIGH = 8'hb4;
    localparam logic [7:0] CTRL_RESET  = 8'h00;
    localparam logic [15:0] DATA_RESET = 16'h0000;

    // mode codes
    typedef enum logic [2:0] {
        MODE_OFF   = 3'b000,
        MODE_VAR   = 3'b001,
        MODE_TWIN8 = 3'b010,
        MODE_TWIN16 = 3'b011,
        MODE_NRZ   = 3'b100,
        MODE_DUAL8 = 3'b101,
        MODE_RZ    = 3'b110,
        MODE_RSVD  = 3'b111
    } dopc_mode_t;

    // clock source codes
    localparam logic [1:0] SRC_NONE = 2'b00;
    localparam logic [1:0] SRC_DIV  = 2'b01;
    localparam logic [1:0] SRC_EXT  = 2'b10;
    localparam logic [1:0] SRC_OSC  = 2'b11;

    // prescaler terminal counts for /1, /4, /16, /64
    localparam logic [5:0] PRE_LIM1  = 6'h00;
    localparam logic [5:0] PRE_LIM4  = 6'h03;
    localparam logic [5:0] PRE_LIM16 = 6'h0f;
    localparam logic [5:0] PRE_LIM64 = 6'h3f;

    // oscillator divide factor is 32 shifted by the code, max code 5
    localparam logic [10:0] DIV_BASE    = 11'h020;
    localparam logic [2:0]  DIV_MAXCODE = 3'h5;

    // control register layout, msb first
    typedef struct packed {
        logic       single_output_off;
        dopc_mode_t mode;
        logic [1:0] prescale;
        logic [1:0] clock_source;
    } dopc_ctrl_t;

    // one output pin: level and active-low drive enable
    typedef struct packed {
        logic val;
        logic oe_n;
    } dopc_pin_t;
endpackage : dopc_pkg

// file: core/dopc_top.sv
// dual output pulse-width / sigma-delta modulator with its sfr port
module dopc_top
    import dopc_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       sfr_wr,
    input  wire logic [7:0] sfr_addr,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata,
    input  wire logic [2:0] cfg_divide_code,
    input  wire logic       cfg_pin_alt,
    input  wire logic       timer_zero_input,
    output dopc_pin_t       output_a_pin_primary,
    output dopc_pin_t       output_b_pin_primary,
    output dopc_pin_t       output_a_pin_alternate,
    output dopc_pin_t       output_b_pin_alternate
);
    dopc_ctrl_t  ctrl;              // pwm_control register
    logic [15:0] reg_a, reg_b;      // committed data pairs
    logic [7:0]  hold_a, hold_b;    // hidden low-byte holding
    logic [15:0] act_a, act_b;      // values used by current cycle
    logic [15:0] cnt;               // modulator counter
    logic [9:0]  div_cnt;           // oscillator divider
    logic [5:0]  pre_cnt;           // prescaler
    logic        ext_q;             // previous external level
    logic [15:0] acc_a, acc_b;      // sigma-delta accumulators
    logic        sd_a, sd_b;        // sigma-delta output bits

    // bus decode
    wire ctrl_wr = sfr_wr && sfr_addr == ADDR_CTRL;
    wire a_lo_wr = sfr_wr && sfr_addr == ADDR_A_LOW;
    wire a_hi_wr = sfr_wr && sfr_addr == ADDR_A_HIGH;
    wire b_lo_wr = sfr_wr && sfr_addr == ADDR_B_LOW;
    wire b_hi_wr = sfr_wr && sfr_addr == ADDR_B_HIGH;
    wire dopc_mode_t mode = ctrl.mode;
    // 8-bit modes take the low byte at once; 16-bit modes hold it
    wire mode8 = mode == MODE_TWIN8 || mode == MODE_DUAL8;

    // source selection; code 00 has no clock and stalls the counter
    wire [2:0]  div_code = cfg_divide_code > DIV_MAXCODE ?
                           DIV_MAXCODE : cfg_divide_code;
    wire [9:0]  div_lim  = 10'((DIV_BASE << div_code) - 11'h001);
    wire        ext_rise = timer_zero_input && !ext_q;
    wire        src_tick = ctrl.clock_source == SRC_OSC ? 1'b1 :
                           ctrl.clock_source == SRC_EXT ? ext_rise :
                           ctrl.clock_source == SRC_DIV ?
                           div_cnt == div_lim : 1'b0;
    wire [5:0]  pre_lim  = ctrl.prescale == 2'b00 ? PRE_LIM1 :
                           ctrl.prescale == 2'b01 ? PRE_LIM4 :
                           ctrl.prescale == 2'b10 ? PRE_LIM16 :
                           PRE_LIM64;
    wire        tick     = src_tick && pre_cnt == pre_lim;
    // return-to-zero: low during the second half of a counter clock; never low at prescale /1
    wire        rz_low   = pre_cnt > (pre_lim >> 1);

    // period ends per mode
    wire wrap_lo  = cnt[7:0] >= act_b[7:0];
    wire wrap_hi  = cnt[15:8] >= act_b[15:8];
    // a zero period in mode one wraps at ffff, the full 65536 range
    wire wrap_all = mode == MODE_VAR   ? cnt >= act_b - 16'h0001 :
                    mode == MODE_TWIN8 ? wrap_lo :
                    cnt == 16'hffff;
    wire cycle_end = tick && (mode == MODE_DUAL8 ? wrap_lo : wrap_all);
    wire [15:0] next_cnt =
        mode == MODE_DUAL8 ?
        {wrap_hi ? 8'h00 : cnt[15:8] + 8'h01,
         wrap_lo ? 8'h00 : cnt[7:0] + 8'h01} :
        wrap_all ? 16'h0000 : cnt + 16'h0001;
    wire [16:0] sum_a = {1'b0, acc_a} + {1'b0, act_a};
    wire [16:0] sum_b = {1'b0, acc_b} + {1'b0, act_b};

    // waveform per mode
    wire next_val_a =
        mode == MODE_TWIN8  ? cnt[7:0] < act_a[7:0] :
        mode == MODE_TWIN16 ? cnt < act_a :
        mode == MODE_NRZ    ? sd_a :
        mode == MODE_DUAL8  ? cnt[7:0] < act_a[7:0] :
        mode == MODE_RZ     ? sd_a && !rz_low : 1'b0;
    wire next_val_b =
        mode == MODE_VAR    ? cnt < act_a :
        mode == MODE_TWIN8  ? cnt[7:0] >= act_b[15:8] &&
                              cnt[7:0] < act_a[15:8] :
        mode == MODE_TWIN16 ? cnt < act_b :
        mode == MODE_NRZ    ? sd_b :
        mode == MODE_DUAL8  ? cnt[15:8] < act_a[15:8] :
        mode == MODE_RZ     ? sd_b && !rz_low : 1'b0;
    // modes 0 and 7 drive nothing; mode 1 leaves the first pin alone
    wire next_drv_b = mode != MODE_OFF && mode != MODE_RSVD;
    wire next_drv_a = next_drv_b && mode != MODE_VAR &&
                      !ctrl.single_output_off;
    wire [7:0] next_rdata =
        sfr_addr == ADDR_CTRL   ? ctrl :
        sfr_addr == ADDR_A_LOW  ? reg_a[7:0] :
        sfr_addr == ADDR_A_HIGH ? reg_a[15:8] :
        sfr_addr == ADDR_B_LOW  ? reg_b[7:0] :
        sfr_addr == ADDR_B_HIGH ? reg_b[15:8] : 8'h00;

    // software registers; low bytes wait in the holding register, except in 8-bit modes where they also land at once
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl   <= CTRL_RESET;
            reg_a  <= DATA_RESET;
            reg_b  <= DATA_RESET;
            hold_a <= 8'h00;
            hold_b <= 8'h00;
        end else begin
            if (ctrl_wr) ctrl <= sfr_wdata;
            if (a_lo_wr) hold_a <= sfr_wdata;
            if (b_lo_wr) hold_b <= sfr_wdata;
            if (a_lo_wr && mode8) reg_a[7:0] <= sfr_wdata;
            if (b_lo_wr && mode8) reg_b[7:0] <= sfr_wdata;
            if (a_hi_wr) reg_a <= {sfr_wdata, hold_a};
            if (b_hi_wr) reg_b <= {sfr_wdata, hold_b};
        end
    end

    // clock chain and counter; a control write restarts everything
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            div_cnt <= 10'h000;
            pre_cnt <= 6'h00;
            cnt     <= 16'h0000;
            ext_q   <= 1'b0;
        end else begin
            ext_q   <= timer_zero_input;
            div_cnt <= ctrl_wr || div_cnt >= div_lim ? 10'h000 :
                       div_cnt + 10'h001;
            if (ctrl_wr) begin
                pre_cnt <= 6'h00;
                cnt     <= 16'h0000;
            end else if (src_tick) begin
                pre_cnt <= tick ? 6'h00 : pre_cnt + 6'h01;
                if (tick) cnt <= next_cnt;
            end
        end
    end

    // new data only at a cycle boundary or a control write, so a running cycle finishes, except output b's high-byte cycle in mode 5, cut at the low-byte wrap
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            act_a <= DATA_RESET;
            act_b <= DATA_RESET;
            acc_a <= 16'h0000;
            acc_b <= 16'h0000;
            sd_a  <= 1'b0;
            sd_b  <= 1'b0;
        end else begin
            if (ctrl_wr || cycle_end) begin
                act_a <= reg_a;
                act_b <= reg_b;
            end
            if (ctrl_wr) begin
                acc_a <= 16'h0000;
                acc_b <= 16'h0000;
                sd_a  <= 1'b0;
                sd_b  <= 1'b0;
            end else if (tick) begin
                acc_a <= sum_a[15:0];
                acc_b <= sum_b[15:0];
                sd_a  <= sum_a[16];
                sd_b  <= sum_b[16];
            end
        end
    end

    // pin stage: all outputs leave from flops, steered to one pair
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sfr_rdata              <= 8'h00;
            output_a_pin_primary   <= 2'b01;
            output_b_pin_primary   <= 2'b01;
            output_a_pin_alternate <= 2'b01;
            output_b_pin_alternate <= 2'b01;
        end else begin
            sfr_rdata <= next_rdata;
            output_a_pin_primary <=
                {next_val_a, !(next_drv_a && !cfg_pin_alt)};
            output_b_pin_primary <=
                {next_val_b, !(next_drv_b && !cfg_pin_alt)};
            output_a_pin_alternate <=
                {next_val_a, !(next_drv_a && cfg_pin_alt)};
            output_b_pin_alternate <=
                {next_val_b, !(next_drv_b && cfg_pin_alt)};
        end
    end

    // checks
    property p_off;
        @(posedge mclk) disable iff (rst)
        (mode == MODE_OFF || mode == MODE_RSVD) |=>
        output_a_pin_primary.oe_n && output_b_pin_primary.oe_n &&
        output_a_pin_alternate.oe_n && output_b_pin_alternate.oe_n;
    endproperty
    a_off: assert property (p_off) else $error("pins driven when off");
    property p_var_pin;
        @(posedge mclk) disable iff (rst)
        mode == MODE_VAR |=> output_a_pin_primary.oe_n &&
        output_a_pin_alternate.oe_n;
    endproperty
    a_var_pin: assert property (p_var_pin)
        else $error("first pin driven in mode one");
    property p_single;
        @(posedge mclk) disable iff (rst)
        ctrl.single_output_off |=> output_a_pin_primary.oe_n &&
        output_a_pin_alternate.oe_n;
    endproperty
    a_single: assert property (p_single)
        else $error("first pin driven while freed");
    property p_clear;
        @(posedge mclk) disable iff (rst)
        ctrl_wr |=> cnt == 16'h0000 && pre_cnt == 6'h00;
    endproperty
    a_clear: assert property (p_clear)
        else $error("counter not cleared");
    property p_div4;
        @(posedge mclk) disable iff (rst || ctrl_wr)
        tick && ctrl.prescale == 2'b01 && ctrl.clock_source == SRC_OSC
        |=> !tick [*3] ##1 tick;
    endproperty
    a_div4: assert property (p_div4) else $error("divide by 4 broken");
    property p_hold;
        @(posedge mclk) disable iff (rst)
        a_lo_wr && !mode8 |=> reg_a == $past(reg_a) &&
        hold_a == $past(sfr_wdata);
    endproperty
    a_hold: assert property (p_hold) else $error("low byte not held");
    property p_commit;
        @(posedge mclk) disable iff (rst)
        a_hi_wr |=> reg_a == {$past(sfr_wdata), $past(hold_a)};
    endproperty
    a_commit: assert property (p_commit) else $error("commit wrong");
    property p_keep;
        @(posedge mclk) disable iff (rst)
        !cycle_end && !ctrl_wr |=> act_b == $past(act_b);
    endproperty
    a_keep: assert property (p_keep)
        else $error("value changed mid cycle");
    property p_alt;
        @(posedge mclk) disable iff (rst)
        cfg_pin_alt |=> output_a_pin_primary.oe_n &&
        output_b_pin_primary.oe_n;
    endproperty
    a_alt: assert property (p_alt) else $error("primary pair driven");
    property p_twin16;
        @(posedge mclk) disable iff (rst)
        mode == MODE_TWIN16 |=>
        output_b_pin_primary.val == ($past(cnt) < $past(act_b));
    endproperty
    a_twin16: assert property (p_twin16)
        else $error("twin16 level wrong");
    c_end:   cover property (@(posedge mclk) cycle_end && mode == MODE_VAR);
    c_sd:    cover property (@(posedge mclk) tick && sd_a && mode == MODE_NRZ);
    c_twin8: cover property (@(posedge mclk) cycle_end && mode == MODE_TWIN8);
    c_rz:    cover property (@(posedge mclk) tick && sd_b && mode == MODE_RZ);
    c_dual8: cover property (@(posedge mclk) cycle_end && mode == MODE_DUAL8);
endmodule // dopc_top

// file: testbench/dopc_load.sv
// filter load model: integrates driven high time on the selected pin pair
module dopc_load
    import dopc_pkg::*;
(
    input  wire logic      mclk,
    input  wire logic      clear,
    input  wire logic      alt,
    input  wire dopc_pin_t pin_a_pri,
    input  wire dopc_pin_t pin_b_pri,
    input  wire dopc_pin_t pin_a_alt,
    input  wire dopc_pin_t pin_b_alt,
    output integer         high_a,
    output integer         high_b
);
    timeunit 1ns;
    timeprecision 1ns;

    wire logic lvl_a; // resolved level of output a at the load
    wire logic lvl_b; // resolved level of output b at the load

    // a released pin sits on the board pull-down, so only driven highs count
    assign lvl_a = alt ? (pin_a_alt.val & ~pin_a_alt.oe_n)
                       : (pin_a_pri.val & ~pin_a_pri.oe_n);
    assign lvl_b = alt ? (pin_b_alt.val & ~pin_b_alt.oe_n)
                       : (pin_b_pri.val & ~pin_b_pri.oe_n);

    // integrator; clear restarts the measurement window
    always @(posedge mclk) begin
        if (clear) begin
            high_a <= 0;
            high_b <= 0;
        end else begin
            // four-state sum: an unknown pin level poisons the count
            high_a <= high_a + 32'(lvl_a);
            high_b <= high_b + 32'(lvl_b);
        end
    end
endmodule // dopc_load

// file: testbench/testbench.sv
// self-checking bench for the dual output modulator
module testbench
    import dopc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic       mclk = 1'b0;
    logic       rst = 1'b1;
    logic       sfr_wr = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_wdata = 8'h00;
    logic [2:0] div_code = 3'h0;  // only codes 0 and 1 are exercised
    logic       pin_alt = 1'b0;   // pin pair select
    logic       tz = 1'b0;        // external source, toggled by run
    logic       clear = 1'b1;     // restarts the load integrator
    logic [7:0] sfr_rdata;
    dopc_pin_t  a_pri, b_pri, a_alt, b_alt;
    integer     high_a, high_b;
    int         mismatches = 0;
    int         n_compared = 0;
    int         cycles = 0;
    int         seed = 32'h0f8e;
    int         r;

    dopc_top u_dopc_top (.mclk(mclk), .rst(rst), .sfr_wr(sfr_wr),
        .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .cfg_divide_code(div_code), .cfg_pin_alt(pin_alt),
        .timer_zero_input(tz), .output_a_pin_primary(a_pri),
        .output_b_pin_primary(b_pri), .output_a_pin_alternate(a_alt),
        .output_b_pin_alternate(b_alt));

    dopc_load u_dopc_load (.mclk(mclk), .clear(clear), .alt(pin_alt),
        .pin_a_pri(a_pri), .pin_b_pri(b_pri), .pin_a_alt(a_alt),
        .pin_b_alt(b_alt), .high_a(high_a), .high_b(high_b));

    // 50 MHz clock
    always #10 mclk = ~mclk;

    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // hang guard: well above the ~73k cycles the whole sequence needs
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 100000) begin
            mismatches++;
            close_out();
        end
    end

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    // one write; strobe left up so back-to-back writes need no gap
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_wr = 1'b1;
        sfr_addr = a;
        sfr_wdata = d;
        @(posedge mclk);
        #1;
    endtask

    // read data is registered, so it is looked at one edge later
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        sfr_wr = 1'b0;
        sfr_addr = a;
        @(posedge mclk);
        #1;
        check("rdata", sfr_rdata, e);
    endtask

    // expected driven-high cycles of one output over a window; the
    // counter steps once per sc cycles and the load sees win - 1 pin
    // values of the new mode, the first sample still shows mode 0
    function automatic int model(logic [7:0] c, bit sec, int a, int b,
                                 int win);
        int pre;
        int sc;
        int d;
        int k;
        int cl;
        int ch;
        int acc;
        int hi;
        bit sd;
        bit lvl;
        pre = 1 << (2 * c[3:2]);
        case (c[1:0])
            2'b00: sc = 0; // no source: the counter stalls at zero
            2'b01: sc = pre * (32 << div_code);
            2'b10: sc = pre * 2; // run gives one rising edge per two cycles
            default: sc = pre;
        endcase
        d = sec ? b : a;
        acc = 0;
        hi = 0;
        sd = 1'b0;
        if (c[6:4] == 3'd0 || c[6:4] == 3'd7) return 0;
        if (!sec && (c[7] || c[6:4] == 3'd1)) return 0;
        for (int m = 0; m < win - 1; m++) begin
            k = sc == 0 ? 0 : m / sc;
            // carry of the accumulator shows one cycle after its tick
            if (sc != 0 && m > 0 && m % sc == 0) begin
                acc = acc + d;
                sd = acc > 65535;
                acc = acc % 65536;
            end
            cl = k % ((b & 255) + 1);
            ch = k % ((b >> 8) + 1);
            case (c[6:4])
                3'd1: lvl = k % (b == 0 ? 65536 : b) < a;
                3'd2: lvl = sec ? cl >= (b >> 8) && cl < (a >> 8)
                                : cl < (a & 255);
                3'd3: lvl = k % 65536 < d;
                3'd5: lvl = sec ? ch < (a >> 8) : cl < (a & 255);
                // return to zero, modelled for the raw oscillator only
                3'd6: lvl = sd && m % pre <= (pre - 1) / 2;
                default: lvl = sd;
            endcase
            hi += int'(lvl);
        end
        return hi;
    endfunction

    // park in mode 0, load both pairs low byte first, start, then measure
    task automatic run(input logic [7:0] c, input logic [15:0] a,
                       input logic [15:0] b, input int win);
        clear = 1'b1;
        wr(ADDR_CTRL, 8'h00);
        wr(ADDR_A_LOW, a[7:0]);
        wr(ADDR_A_HIGH, a[15:8]);
        wr(ADDR_B_LOW, b[7:0]);
        wr(ADDR_B_HIGH, b[15:8]);
        wr(ADDR_CTRL, c);
        sfr_wr = 1'b0;
        clear = 1'b0;
        // an external source gets a rising edge every other cycle and
        // is back low when the window closes
        for (int i = 0; i < win; i++) begin
            @(posedge mclk);
            #1;
            tz = c[1:0] == 2'b10 && i < win - 1 && !tz;
        end
        check("high_a", high_a, model(c, 1'b0, a, b, win));
        check("high_b", high_b, model(c, 1'b1, a, b, win));
        $display("test ctrl %h done", c);
    endtask

    // main sequence
    initial begin
        repeat (5) @(posedge mclk);
        #1;
        rst = 1'b0;
        rd(ADDR_CTRL, CTRL_RESET);
        rd(8'hb0, 8'h00);
        check("pins", {a_pri, b_pri, a_alt, b_alt}, 8'h55);
        r = $random(seed);
        run(8'h33, {10'h0, r[5:0]} + 16'h1, {10'h0, r[11:6]} + 16'h1,
            200);
        for (int k = 0; k < 4; k++) begin
            run({4'h3, 2'(k), 2'b11}, 16'h3, 16'h2, 400);
        end
        div_code = 3'(r[12]);
        run(8'h31, 16'h3, 16'h1, 400);
        run(8'h32, 16'h3, 16'h0, 100);
        run(8'h30, 16'h3, 16'h0, 100);
        run(8'h13, 16'h6, 16'h14, 75);
        run(8'h23, 16'h0604, 16'h0209, 100);
        run(8'h53, 16'h0302, 16'h0504, 100);
        pin_alt = 1'b1;
        run(8'hb3, 16'h5, 16'h7, 100);
        check("oe_n", {a_pri.oe_n, b_pri.oe_n, a_alt.oe_n, b_alt.oe_n},
              4'he);
        pin_alt = 1'b0;
        run(8'h03, 16'h5, 16'h7, 50);
        run(8'h73, 16'h5, 16'h7, 50);
        check("oe_n", {a_pri.oe_n, b_pri.oe_n, a_alt.oe_n, b_alt.oe_n},
              4'hf);
        wr(ADDR_CTRL, 8'h33);
        wr(ADDR_A_LOW, 8'h5a);
        rd(ADDR_A_LOW, 8'h05);
        wr(ADDR_A_HIGH, 8'hc3);
        rd(ADDR_A_LOW, 8'h5a);
        rd(ADDR_A_HIGH, 8'hc3);
        $display("test register hold done");
        r = $random(seed);
        run(8'h43, r[15:0], r[31:16], 65538);
        r = $random(seed);
        run(8'h67, r[15:0], r[31:16], 4000);
        close_out();
    end
endmodule // testbench
